// ==== pgsc_pkg.sv ====
// Shared constants and types of the PRBS generator with serial control
package pgsc_pkg;
	// Control register layout
	localparam int          CTL_BYTES           = 9;
	localparam int          CTL_BITS            = 72;
	localparam logic [3:0]  CTL_LAST_IDX        = 4'h8;
	localparam logic [3:0]  IDX_ZERO_LOW        = 4'h0;
	localparam logic [3:0]  IDX_ZERO_MID        = 4'h1;
	localparam logic [3:0]  IDX_ZERO_HIGH       = 4'h2;
	localparam logic [3:0]  IDX_POLE_FIRST      = 4'h3;
	localparam logic [3:0]  IDX_POLE_SECOND     = 4'h4;
	localparam logic [3:0]  IDX_DC_LEVEL        = 4'h5;
	localparam logic [3:0]  IDX_BANDWIDTH       = 4'h6;
	localparam logic [3:0]  IDX_LINEARITY       = 4'h7;
	localparam logic [3:0]  IDX_MODE            = 4'h8;
	localparam int          MODE_SHORT_POLY_BIT = 0;
	localparam int          MODE_MONITOR_BIT    = 1;
	localparam int          EQ_BITS             = 64;
	// Byte i sits at bits [i*8 +: 8]; mode byte on top
	localparam logic [71:0] CTL_DEFAULTS        = 72'h02_0000_0000_0000_0000;
	// Shift register
	localparam int          LFSR_LONG           = 10;
	localparam int          LFSR_SHORT          = 9;
	localparam int          LONG_TAP_A          = 9;
	localparam int          LONG_TAP_B          = 6;
	localparam int          SHORT_TAP_A         = 8;
	localparam int          SHORT_TAP_B         = 3;
	localparam logic [9:0]  LFSR_ONES           = 10'h3ff;
	// Two-wire target address, fixed middle bits
	localparam logic [3:0]  I2C_ADDR_MID        = 4'h0;
	localparam logic [3:0]  I2C_BYTE_BITS       = 4'h8;
	localparam logic [3:0]  I2C_LAST_BIT        = 4'h7;
	// Synchroniser bit positions and idle levels
	localparam int          SY_LINE             = 0;
	localparam int          SY_PSEL             = 1;
	localparam int          SY_STRAP0           = 2;
	localparam int          SY_STRAP5           = 3;
	localparam int          SY_STRAP6           = 4;
	localparam int          SY_SCLK             = 5;
	localparam int          SY_SDIN             = 6;
	localparam int          SY_CSN              = 7;
	localparam int          SY_SCL              = 8;
	localparam int          SY_SDA              = 9;
	localparam int          SY_W                = 10;
	localparam logic [9:0]  SY_IDLE             = 10'h380;
	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_RECV,
		I2C_ACK,
		I2C_SEND,
		I2C_MACK
	} pgsc_i2c_state_t;
endpackage

// ==== pgsc_stream_if.sv ====
// Valid and ready stream between the pattern source, buffer and output stage
`timescale 1ns/1ps
`default_nettype none
interface pgsc_stream_if #(parameter int W = 1);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== pgsc_lfsr.sv ====
// Selectable 9- or 10-stage pattern shift register
`timescale 1ns/1ps
`default_nettype none
module pgsc_lfsr
	import pgsc_pkg::*;
(
	// Clock, reset and preset
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  preset_n,
	// Control
	input  wire logic  short_sel,
	input  wire logic  advance,
	// Pattern stream
	pgsc_stream_if.src out_if
);
	logic [LFSR_LONG-1:0] stage_ff;
	logic                 fresh_ff;
	wire                  fb_long;
	wire                  fb_short;
	wire                  feedback;
	wire                  step;

	assign fb_long      = stage_ff[LONG_TAP_A] ^ stage_ff[LONG_TAP_B];
	assign fb_short     = stage_ff[SHORT_TAP_A] ^ stage_ff[SHORT_TAP_B];
	assign feedback     = short_sel ? fb_short : fb_long;
	assign out_if.valid = advance;
	assign step         = advance && out_if.ready;
	assign out_if.data  = short_sel ? stage_ff[LFSR_SHORT-1] : stage_ff[LFSR_LONG-1];

	always_ff @(posedge clk or negedge preset_n) begin
		if (!preset_n) begin
			stage_ff <= LFSR_ONES;
			fresh_ff <= 1'b1;
		end else if (!rst_n) begin
			stage_ff <= LFSR_ONES;
			fresh_ff <= 1'b1;
		end else if (step) begin
			stage_ff <= {stage_ff[LFSR_LONG-2:0], feedback};
			fresh_ff <= 1'b0;
		end
	end

	a_preset_ones: assert property (@(posedge clk) disable iff (!rst_n)
		!preset_n |-> stage_ff == LFSR_ONES) else $error("preset did not give all ones");
	a_resume_first: assert property (@(posedge clk) disable iff (!rst_n || !preset_n)
		fresh_ff && step |=> stage_ff == {LFSR_ONES[LFSR_LONG-2:0], 1'b0})
		else $error("first step after preset wrong");
	a_feedback_long: assert property (@(posedge clk) disable iff (!rst_n || !preset_n)
		step && !short_sel |=> stage_ff[0] == $past(fb_long)
		&& stage_ff[LFSR_LONG-1:1] == $past(stage_ff[LFSR_LONG-2:0]))
		else $error("long feedback wrong");
	a_feedback_short: assert property (@(posedge clk) disable iff (!rst_n || !preset_n)
		step && short_sel |=> stage_ff[0] == $past(stage_ff[SHORT_TAP_A] ^ stage_ff[SHORT_TAP_B]))
		else $error("short feedback wrong");
	a_hold_idle: assert property (@(posedge clk) disable iff (!rst_n || !preset_n)
		!step |=> $stable(stage_ff)) else $error("register moved without line edge");
	a_no_lockup: assert property (@(posedge clk) disable iff (!rst_n || !preset_n)
		short_sel ? stage_ff[LFSR_SHORT-1:0] != 9'h000 : stage_ff != 10'h000)
		else $error("register locked at zero");
endmodule
`default_nettype wire

// ==== pgsc_buf2.sv ====
// Small ring buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pgsc_buf2 #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// Streams
	pgsc_stream_if.snk in_if,
	pgsc_stream_if.src out_if
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
			$error("DEPTH must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      cnt_ff;
	wire              push;
	wire              pop;

	assign in_if.ready  = (cnt_ff != FULL_CNT);
	assign out_if.valid = (cnt_ff != '0);
	assign out_if.data  = mem_ff[rd_ff];
	assign push         = in_if.valid && in_if.ready;
	assign pop          = out_if.valid && out_if.ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_if.data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff  <= push ? wr_ff + 1'b1 : wr_ff;
			rd_ff  <= pop ? rd_ff + 1'b1 : rd_ff;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ==== pgsc_top.sv ====
// Pattern generator with three-wire and two-wire control register access
`timescale 1ns/1ps
`default_nettype none
module pgsc_top
	import pgsc_pkg::*;
(
	// Clock and reset
	input  wire logic               CLK,
	input  wire logic               RST_N,
	// Pattern clock and preset
	input  wire logic               LINE_CLK,
	input  wire logic               PRESET_N,
	// Pattern outputs
	input  wire logic               OUT_READY,
	output var  logic               MAIN_OUT,
	output var  logic               MON_OUT,
	// Control values
	output wire logic [EQ_BITS-1:0] EQ_CODES,
	output wire logic               SHORT_POLY_SELECT,
	output wire logic               MONITOR_BUFFER_EN,
	// Port selection and address straps
	input  wire logic               PORT_SELECT_PIN,
	input  wire logic [2:0]         ADDR_STRAP,
	// Three-wire port
	input  wire logic               SERIAL_CLOCK_IN,
	input  wire logic               SERIAL_DATA_IN,
	input  wire logic               SERIAL_SELECT_N,
	output wire logic               SERIAL_READBACK_OUT,
	output var  logic               SERIAL_READBACK_OE,
	// Two-wire port
	input  wire logic               SCL_IN,
	input  wire logic               SDA_IN,
	output var  logic               SDA_OUT,
	output var  logic               SDA_OE
);
	// Input synchronisers
	logic [SY_W-1:0] sy1_ff;
	logic [SY_W-1:0] sy2_ff;
	logic [SY_W-1:0] prev_ff;
	wire  [SY_W-1:0] raw_in;

	assign raw_in = {SDA_IN, SCL_IN, SERIAL_SELECT_N, SERIAL_DATA_IN, SERIAL_CLOCK_IN,
		ADDR_STRAP[2], ADDR_STRAP[1], ADDR_STRAP[0], PORT_SELECT_PIN, LINE_CLK};

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sy1_ff  <= SY_IDLE;
			sy2_ff  <= SY_IDLE;
			prev_ff <= SY_IDLE;
		end else begin
			sy1_ff  <= raw_in;
			sy2_ff  <= sy1_ff;
			prev_ff <= sy2_ff;
		end
	end

	// Preset: asynchronous assertion, synchronised release
	logic [1:0] preset_sync_ff;
	wire        preset_n_int;

	always_ff @(posedge CLK or negedge PRESET_N) begin
		if (!PRESET_N) begin
			preset_sync_ff <= 2'h0;
		end else begin
			preset_sync_ff <= {preset_sync_ff[0], 1'b1};
		end
	end
	assign preset_n_int = preset_sync_ff[1];

	// Edge and mode decode
	wire       line_rise;
	wire       i2c_mode;
	wire       spi_mode;
	wire       sclk_rise;
	wire       sclk_fall;
	wire       cs_low;
	wire       cs_rise;
	wire       cs_fall;
	wire       scl_rise;
	wire       scl_fall;
	wire       i2c_start;
	wire       i2c_stop;
	wire       sda_s;
	wire [6:0] own_addr;

	assign line_rise = sy2_ff[SY_LINE] & ~prev_ff[SY_LINE];
	assign i2c_mode  = sy2_ff[SY_PSEL];
	assign spi_mode  = ~sy2_ff[SY_PSEL];
	assign sclk_rise = sy2_ff[SY_SCLK] & ~prev_ff[SY_SCLK];
	assign sclk_fall = ~sy2_ff[SY_SCLK] & prev_ff[SY_SCLK];
	assign cs_low    = ~sy2_ff[SY_CSN];
	assign cs_rise   = sy2_ff[SY_CSN] & ~prev_ff[SY_CSN];
	assign cs_fall   = ~sy2_ff[SY_CSN] & prev_ff[SY_CSN];
	assign scl_rise  = sy2_ff[SY_SCL] & ~prev_ff[SY_SCL];
	assign scl_fall  = ~sy2_ff[SY_SCL] & prev_ff[SY_SCL];
	assign sda_s     = sy2_ff[SY_SDA];
	assign i2c_start = sy2_ff[SY_SCL] & prev_ff[SY_SCL] & prev_ff[SY_SDA] & ~sda_s;
	assign i2c_stop  = sy2_ff[SY_SCL] & prev_ff[SY_SCL] & ~prev_ff[SY_SDA] & sda_s;
	assign own_addr  = {sy2_ff[SY_STRAP6], sy2_ff[SY_STRAP5], I2C_ADDR_MID,
		sy2_ff[SY_STRAP0]};

	// Control register storage
	logic [7:0]          ctl_byte [CTL_BYTES];
	wire  [CTL_BITS-1:0] ctl_flat;
	logic [CTL_BITS-1:0] spi_sh_ff;
	wire                 spi_commit;
	logic                i2c_we;
	logic [3:0]          i2c_ptr_ff;
	logic [7:0]          i2c_sh_ff;

	assign spi_commit = spi_mode & cs_rise;

	generate
		for (genvar i = 0; i < CTL_BYTES; i++) begin : g_ctl
			logic [7:0] byte_ff;
			always_ff @(posedge CLK) begin
				if (!RST_N) begin
					byte_ff <= CTL_DEFAULTS[i*8 +: 8];
				end else if (spi_commit) begin
					byte_ff <= spi_sh_ff[i*8 +: 8];
				end else if (i2c_we && i2c_ptr_ff == 4'(i)) begin
					byte_ff <= i2c_sh_ff;
				end
			end
			assign ctl_byte[i]         = byte_ff;
			assign ctl_flat[i*8 +: 8] = byte_ff;
		end
	endgenerate

	assign EQ_CODES          = ctl_flat[EQ_BITS-1:0];
	assign SHORT_POLY_SELECT = ctl_byte[IDX_MODE][MODE_SHORT_POLY_BIT];
	assign MONITOR_BUFFER_EN = ctl_byte[IDX_MODE][MODE_MONITOR_BIT];

	// Three-wire port
	logic [CTL_BITS-1:0] rb_sh_ff;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			spi_sh_ff <= '0;
		end else if (spi_mode && cs_low && sclk_rise) begin
			spi_sh_ff <= {spi_sh_ff[CTL_BITS-2:0], sy2_ff[SY_SDIN]};
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rb_sh_ff           <= '0;
			SERIAL_READBACK_OE <= 1'b0;
		end else begin
			if (cs_fall) begin
				rb_sh_ff <= ctl_flat;
			end else if (cs_low && sclk_fall) begin
				rb_sh_ff <= {rb_sh_ff[CTL_BITS-2:0], 1'b0};
			end
			SERIAL_READBACK_OE <= spi_mode & cs_low;
		end
	end
	assign SERIAL_READBACK_OUT = rb_sh_ff[CTL_BITS-1];

	// Two-wire target
	pgsc_i2c_state_t i2c_state_ff;
	pgsc_i2c_state_t nxt_state;
	logic [3:0]      i2c_bits_ff;
	logic [3:0]      nxt_bits;
	logic [1:0]      i2c_phase_ff;
	logic [1:0]      nxt_phase;
	logic            i2c_rw_ff;
	logic            nxt_rw;
	logic [7:0]      nxt_sh;
	logic [7:0]      i2c_tx_ff;
	logic [7:0]      nxt_tx;
	logic [3:0]      nxt_ptr;
	logic            nxt_oe;
	logic            mack_ok_ff;
	logic            nxt_mack;
	wire             byte_done;
	wire             addr_hit;
	wire             ptr_valid;
	wire  [7:0]      rd_byte;
	wire             i2c_decide;

	assign byte_done  = (i2c_bits_ff == I2C_BYTE_BITS);
	assign addr_hit   = (i2c_sh_ff[7:1] == own_addr);
	assign ptr_valid  = (i2c_ptr_ff <= CTL_LAST_IDX);
	assign rd_byte    = ptr_valid ? ctl_byte[i2c_ptr_ff] : 8'h00;
	assign i2c_decide = i2c_mode && !i2c_start && !i2c_stop && scl_fall && byte_done
		&& i2c_state_ff == I2C_RECV;

	always_comb begin
		nxt_state = i2c_state_ff;
		nxt_bits  = i2c_bits_ff;
		nxt_phase = i2c_phase_ff;
		nxt_rw    = i2c_rw_ff;
		nxt_sh    = i2c_sh_ff;
		nxt_tx    = i2c_tx_ff;
		nxt_ptr   = i2c_ptr_ff;
		nxt_oe    = SDA_OE;
		nxt_mack  = mack_ok_ff;
		i2c_we    = 1'b0;
		if (!i2c_mode || i2c_stop) begin
			nxt_state = I2C_IDLE;
			nxt_oe    = 1'b0;
		end else if (i2c_start) begin
			nxt_state = I2C_RECV;
			nxt_bits  = 4'h0;
			nxt_phase = 2'h0;
			nxt_oe    = 1'b0;
		end else begin
			case (i2c_state_ff)
				I2C_RECV: begin
					if (scl_rise && !byte_done) begin
						nxt_sh   = {i2c_sh_ff[6:0], sda_s};
						nxt_bits = i2c_bits_ff + 4'h1;
					end else if (scl_fall && byte_done) begin
						nxt_state = I2C_ACK;
						nxt_oe    = 1'b1;
						case (i2c_phase_ff)
							2'h0: begin
								if (addr_hit) begin
									nxt_rw = i2c_sh_ff[0];
								end else begin
									nxt_state = I2C_IDLE;
									nxt_oe    = 1'b0;
								end
							end
							2'h1: nxt_ptr = i2c_sh_ff[3:0];
							default: i2c_we = ptr_valid;
						endcase
					end
				end
				I2C_ACK: begin
					if (scl_fall) begin
						nxt_bits = 4'h0;
						if (i2c_phase_ff == 2'h0 && i2c_rw_ff) begin
							nxt_state = I2C_SEND;
							nxt_tx    = rd_byte;
							nxt_oe    = ~rd_byte[7];
						end else begin
							nxt_state = I2C_RECV;
							nxt_oe    = 1'b0;
							if (i2c_phase_ff != 2'h2) begin
								nxt_phase = i2c_phase_ff + 2'h1;
							end
						end
					end
				end
				I2C_SEND: begin
					if (scl_fall) begin
						if (i2c_bits_ff == I2C_LAST_BIT) begin
							nxt_state = I2C_MACK;
							nxt_oe    = 1'b0;
							nxt_mack  = 1'b0;
						end else begin
							nxt_tx   = {i2c_tx_ff[6:0], 1'b0};
							nxt_oe   = ~i2c_tx_ff[6];
							nxt_bits = i2c_bits_ff + 4'h1;
						end
					end
				end
				I2C_MACK: begin
					if (scl_rise) begin
						if (!sda_s) begin
							nxt_mack = 1'b1;
							nxt_ptr  = i2c_ptr_ff + 4'h1;
						end else begin
							nxt_state = I2C_IDLE;
						end
					end else if (scl_fall && mack_ok_ff) begin
						nxt_mack  = 1'b0;
						nxt_state = I2C_SEND;
						nxt_bits  = 4'h0;
						nxt_tx    = rd_byte;
						nxt_oe    = ~rd_byte[7];
					end
				end
				default: begin
					nxt_state = I2C_IDLE;
					nxt_oe    = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			i2c_state_ff <= I2C_IDLE;
			i2c_bits_ff  <= 4'h0;
			i2c_phase_ff <= 2'h0;
			i2c_rw_ff    <= 1'b0;
			i2c_sh_ff    <= 8'h00;
			i2c_tx_ff    <= 8'h00;
			i2c_ptr_ff   <= 4'h0;
			mack_ok_ff   <= 1'b0;
			SDA_OE       <= 1'b0;
			SDA_OUT      <= 1'b0;
		end else begin
			i2c_state_ff <= nxt_state;
			i2c_bits_ff  <= nxt_bits;
			i2c_phase_ff <= nxt_phase;
			i2c_rw_ff    <= nxt_rw;
			i2c_sh_ff    <= nxt_sh;
			i2c_tx_ff    <= nxt_tx;
			i2c_ptr_ff   <= nxt_ptr;
			mack_ok_ff   <= nxt_mack;
			SDA_OE       <= nxt_oe;
			SDA_OUT      <= 1'b0;
		end
	end

	// Pattern path: generator, buffer, output stage
	pgsc_stream_if #(.W(1)) gen_if ();
	pgsc_stream_if #(.W(1)) out_if ();

	pgsc_lfsr u_lfsr (
		.clk       (CLK),
		.rst_n     (RST_N),
		.preset_n  (preset_n_int),
		.short_sel (SHORT_POLY_SELECT),
		.advance   (line_rise),
		.out_if    (gen_if.src)
	);

	pgsc_buf2 #(.WIDTH(1), .DEPTH(2)) u_buf (
		.clk    (CLK),
		.rst_n  (RST_N),
		.in_if  (gen_if.snk),
		.out_if (out_if.src)
	);

	assign out_if.ready = OUT_READY;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			MAIN_OUT <= 1'b0;
			MON_OUT  <= 1'b0;
		end else begin
			if (out_if.valid && out_if.ready) begin
				MAIN_OUT <= out_if.data[0];
			end
			if (!MONITOR_BUFFER_EN) begin
				MON_OUT <= 1'b0;
			end else if (out_if.valid && out_if.ready) begin
				MON_OUT <= out_if.data[0];
			end
		end
	end

	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_read_acked;
		i2c_mode && !i2c_start && !i2c_stop && i2c_state_ff == I2C_MACK && scl_rise && !sda_s;
	endsequence
	sequence s_next_fall;
		i2c_mode && !i2c_start && !i2c_stop && scl_fall;
	endsequence

	a_read_advance: assert property (s_read_acked ##[1:15] s_next_fall |=>
		i2c_state_ff == I2C_SEND && i2c_tx_ff == $past(rd_byte))
		else $error("acked read did not send next byte");
	a_read_ptr_inc: assert property (s_read_acked |=> i2c_ptr_ff == $past(i2c_ptr_ff) + 4'h1)
		else $error("read pointer not advanced");
	a_addr_ignore: assert property (i2c_decide && i2c_phase_ff == 2'h0 && !addr_hit |=>
		i2c_state_ff == I2C_IDLE && !SDA_OE) else $error("mismatched address answered");
	a_addr_ack: assert property (i2c_decide && i2c_phase_ff == 2'h0 && i2c_sh_ff[7:1] ==
		{sy2_ff[SY_STRAP6], sy2_ff[SY_STRAP5], 4'h0, sy2_ff[SY_STRAP0]} |=> SDA_OE)
		else $error("own address not acknowledged");
	a_reg_select: assert property (i2c_decide && i2c_phase_ff == 2'h1 |=>
		i2c_ptr_ff == $past(i2c_sh_ff[3:0])) else $error("register byte not taken");
	a_range_guard: assert property (i2c_decide && i2c_phase_ff == 2'h2 && !ptr_valid |=>
		$stable(ctl_flat)) else $error("out of range write changed register");
	a_spi_commit: assert property (spi_commit |=> ctl_flat == $past(spi_sh_ff))
		else $error("select rise did not load register");
	a_spi_sample: assert property (spi_mode && cs_low && sclk_rise |=>
		spi_sh_ff[0] == $past(sy2_ff[SY_SDIN])) else $error("serial bit not sampled");
	a_readback_float: assert property (sy2_ff[SY_CSN] |=> !SERIAL_READBACK_OE)
		else $error("readback driven while deselected");
	a_port_exclusive: assert property (i2c_mode ##1 i2c_mode |-> !SERIAL_READBACK_OE)
		else $error("three-wire readback active in two-wire mode");
	a_i2c_quiet: assert property (spi_mode ##1 spi_mode |-> !SDA_OE)
		else $error("two-wire driven in three-wire mode");
	a_monitor_off: assert property (!MONITOR_BUFFER_EN |=> !MON_OUT)
		else $error("monitor active while disabled");
	a_reset_defaults: assert property (@(posedge CLK) disable iff (1'b0)
		!RST_N |=> ctl_flat == CTL_DEFAULTS) else $error("register default wrong");
endmodule
`default_nettype wire

// ==== pgsc_host.sv ====
// Off-chip host model for the three-wire and two-wire control ports
`timescale 1ns/1ps
`default_nettype none
module pgsc_host (
	// Three-wire port
	output var  logic sclk,
	output var  logic sdin,
	output var  logic csn,
	input  wire logic rb_out,
	input  wire logic rb_oe,
	// Two-wire port, pulled-up data line
	output var  logic scl,
	output wire logic sda,
	input  wire logic sda_oe
);
	logic h_low;
	assign sda = ~(h_low | sda_oe);
	initial begin
		{sclk, sdin, csn, scl, h_low} = 5'h06;
	end
	// Clock idles low; data changes with each fall
	task automatic spi(input logic [71:0] w, output logic [71:0] r);
		csn = 1'b0;
		#200;
		for (int i = 71; i >= 0; i--) begin
			sdin = w[i];
			#200;
			sclk = 1'b1;
			r[i] = rb_oe ? rb_out : 1'bx;
			#200;
			sclk = 1'b0;
		end
		#200;
		csn = 1'b1;
		sdin = ~sdin;
		#400;
	endtask
	task automatic bit_x(input logic b, output logic s);
		h_low = ~b;
		#200;
		scl = 1'b1;
		s = sda;
		#200;
		scl = 1'b0;
	endtask
	task automatic start;
		h_low = 1'b0;
		#100;
		scl = 1'b1;
		#200;
		h_low = 1'b1;
		#200;
		scl = 1'b0;
	endtask
	task automatic stop;
		h_low = 1'b1;
		#200;
		scl = 1'b1;
		#200;
		h_low = 1'b0;
		#400;
	endtask
	task automatic xbyte(input logic [7:0] w, input logic mk, output logic [7:0] r,
			output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
		bit_x(mk, s);
		ack = ~s;
	endtask
endmodule
`default_nettype wire

// ==== pgsc_top_bench.sv ====
// Self-checking bench of the pattern generator with serial control
`timescale 1ns/1ps
`default_nettype none
module pgsc_top_bench
	import pgsc_pkg::*;
();
	logic               clk = 1'b0, rst_n = 1'b0, line_clk = 1'b0, preset_n = 1'b1;
	logic               out_ready = 1'b1, port_sel = 1'b0, last_bit, ack;
	logic [2:0]         strap = 3'h5;
	logic               main_out, mon_out, short_sel, mon_en, rb_out, rb_oe, sda_out, sda_oe;
	logic               sclk, sdin, csn, scl, sda;
	logic [EQ_BITS-1:0] eq;
	logic [71:0]        exp_ctl, rd;
	logic [9:0]         lfsr;
	logic [7:0]         rb8;
	int                 n_mismatch = 0, checked = 0;
	always #10 clk = ~clk;
	pgsc_top dut (.CLK(clk), .RST_N(rst_n), .LINE_CLK(line_clk), .PRESET_N(preset_n),
		.OUT_READY(out_ready), .MAIN_OUT(main_out), .MON_OUT(mon_out), .EQ_CODES(eq),
		.SHORT_POLY_SELECT(short_sel), .MONITOR_BUFFER_EN(mon_en),
		.PORT_SELECT_PIN(port_sel), .ADDR_STRAP(strap), .SERIAL_CLOCK_IN(sclk),
		.SERIAL_DATA_IN(sdin), .SERIAL_SELECT_N(csn), .SERIAL_READBACK_OUT(rb_out),
		.SERIAL_READBACK_OE(rb_oe), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE(sda_oe));
	pgsc_host host (.sclk(sclk), .sdin(sdin), .csn(csn), .rb_out(rb_out), .rb_oe(rb_oe),
		.scl(scl), .sda(sda), .sda_oe(sda_oe & ~sda_out));
	task automatic check(input logic [71:0] seen, input logic [71:0] want);
		checked++;
		if (seen !== want) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic end_sim;
		if (n_mismatch == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic pulse;
		line_clk = 1'b1;
		#80;
		line_clk = 1'b0;
		#80;
	endtask
	// Reference register: emit last stage, then step
	task automatic adv(output logic e);
		e = exp_ctl[64] ? lfsr[8] : lfsr[9];
		lfsr = {lfsr[8:0], exp_ctl[64] ? lfsr[8] ^ lfsr[3] : lfsr[9] ^ lfsr[6]};
		last_bit = e;
	endtask
	task automatic step_check(input int n);
		logic e;
		for (int i = 0; i < n; i++) begin
			pulse();
			adv(e);
			check(main_out, e);
			check(mon_out, e & exp_ctl[65]);
		end
	endtask
	task automatic cfg(input logic [71:0] w);
		host.spi(w, rd);
		check(rd, exp_ctl);
		exp_ctl = w;
		check({mon_en, short_sel, eq}, exp_ctl[65:0]);
		check(rb_oe, 1'b0);
	endtask
	task automatic t_spi;
		check({mon_en, short_sel, eq, rb_oe, sda_oe}, 68'h8_0000_0000_0000_0000);
		cfg({8'h03, 64'h8877_6655_4433_2211});
		port_sel = 1'b1;
		host.spi(72'h0, rd);
		check({mon_en, short_sel, eq}, exp_ctl[65:0]);
		port_sel = 1'b0;
	endtask
	task automatic t_pattern(input logic [7:0] mode, input int n);
		cfg({mode, exp_ctl[63:0]});
		preset_n = 1'b0;
		repeat (3) pulse();
		check(main_out, 1'b1);
		preset_n = 1'b1;
		#80;
		lfsr = LFSR_ONES;
		step_check(n);
	endtask
	task automatic t_stall;
		logic e;
		out_ready = 1'b0;
		repeat (5) pulse();
		check(main_out, last_bit);
		out_ready = 1'b1;
		adv(e);
		adv(e);
		#100;
		check(main_out, e);
		step_check(20);
	endtask
	task automatic t_i2c;
		port_sel = 1'b1;
		#200;
		host.start();
		host.xbyte(8'h82, 1'b1, rb8, ack);
		check(ack, 1'b1);
		host.xbyte(8'hf5, 1'b1, rb8, ack);
		host.xbyte(8'h5a, 1'b1, rb8, ack);
		host.xbyte(8'ha5, 1'b1, rb8, ack);
		host.stop();
		exp_ctl[40+:8] = 8'ha5;
		check(eq, exp_ctl[63:0]);
		host.start();
		host.xbyte(8'h86, 1'b1, rb8, ack);
		check(ack, 1'b0);
		host.xbyte(8'h03, 1'b1, rb8, ack);
		host.xbyte(8'h00, 1'b1, rb8, ack);
		host.stop();
		host.start();
		host.xbyte(8'h82, 1'b1, rb8, ack);
		host.xbyte(8'h0c, 1'b1, rb8, ack);
		host.xbyte(8'h77, 1'b1, rb8, ack);
		host.stop();
		check({mon_en, short_sel, eq}, exp_ctl[65:0]);
		host.start();
		host.xbyte(8'h82, 1'b1, rb8, ack);
		host.xbyte(8'h04, 1'b1, rb8, ack);
		host.start();
		host.xbyte(8'h83, 1'b1, rb8, ack);
		host.xbyte(8'hff, 1'b0, rb8, ack);
		check(rb8, exp_ctl[32+:8]);
		host.xbyte(8'hff, 1'b1, rb8, ack);
		check(rb8, exp_ctl[40+:8]);
		host.stop();
	endtask
	initial begin
		exp_ctl = CTL_DEFAULTS;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_spi();
		t_pattern(8'h03, 520);
		t_stall();
		t_pattern(8'h00, 1030);
		t_i2c();
		end_sim();
	end
	initial begin
		#1_000_000;
		n_mismatch++;
		end_sim();
	end
endmodule
`default_nettype wire
